// File: hw/nest_accept.sv
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// (R01) Accepting any request clears accept enable
// (R02) Enable instruction sets accept enable
// (R03) Equal or higher priority nests when enabled
// (R04) Ineligible requests stay pending, never dropped
// (R05) Pending accepted after one main instruction
// (R06) High-level service: only high-level requests nest
// (R07) Idle/low/software service: both levels nest
// (R08) Software interrupt always taken
// (R09) Deferring instruction blocks acceptance one more
// (R10) Status word and enable instructions defer
// (R11) Flag register manipulation defers too
// (R12) Software interrupt not deferring, blocks maskables
// (R13) Priority never affects request flag setting
// (R14) Maskable accept copies priority to in-service
// (R15) Higher priority first, ties by index
// (R16) Returns and pop restore saved status word
// (R17) Evaluate pending at every undeferred boundary
module nest_accept
  import nest_accept_pkg::*;
(
  // Clock and reset
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  // APB slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [nest_accept_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // Peripheral request lines (asynchronous)
  input  wire logic [nest_accept_pkg::SRC_N-1:0] src_req,
  // Core instruction sequencer
  input  wire logic                           instr_done,
  input  wire logic                           instr_defers,
  input  wire logic                           enable_interrupts_instr,
  input  wire logic                           disable_interrupts_instr,
  input  wire logic                           software_interrupt_instr,
  input  wire logic                           return_from_vectored_instr,
  input  wire logic                           return_from_software_instr,
  input  wire logic                           psw_load_instr,
  input  wire logic [7:0]                     psw_load_value,
  // Acceptance towards the core
  output logic                                accept_pulse,
  output logic                                accept_maskable,
  output logic      [nest_accept_pkg::SRC_W-1:0] accept_source,
  output logic      [7:0]                     stacked_psw,
  // Status word view
  output logic                                accept_enable_flag,
  output logic                                in_service_level_flag,
  // Interrupt line
  output logic                                irq
);

  import nest_accept_pkg::*;

  // ==========================================================================
  // State
  logic [SRC_N-1:0] request_flags_r;
  logic [SRC_N-1:0] mask_flags_r;
  logic [SRC_N-1:0] source_priority_flag_r;
  logic             ie_r;
  logic             isp_r;
  logic             hold_r;
  logic [EVT_N-1:0] evt_status_r;
  logic [EVT_N-1:0] evt_enable_r;
  logic             accept_pulse_r;
  logic             accept_maskable_r;
  logic [SRC_W-1:0] accept_source_r;
  logic [7:0]       stacked_psw_r;
  logic [SRC_W-1:0] service_src_r;
  logic [31:0]      prdata_r;
  logic             pslverr_r;

  // ==========================================================================
  // Bus decode
  logic        setup_ph;
  logic        wr_acc;
  logic        addr_ok;
  logic        wr_req;
  logic        wr_mask;
  logic        wr_prio;
  logic        wr_psw;
  logic        wr_clr;
  logic        wr_en;
  logic [7:0]  psw_now;

  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  assign pready   = penable;

  always_comb begin
    unique case (paddr)
      OFF_REQ_FLAGS, OFF_MASK_FLAGS, OFF_PRIO_FLAGS, OFF_PSW,
      OFF_EVT_STATUS, OFF_EVT_CLEAR, OFF_EVT_ENABLE, OFF_SERVICE: addr_ok = 1'b1;
      default:                                                    addr_ok = 1'b0;
    endcase
  end

  assign wr_req  = wr_acc & (paddr == OFF_REQ_FLAGS);
  assign wr_mask = wr_acc & (paddr == OFF_MASK_FLAGS);
  assign wr_prio = wr_acc & (paddr == OFF_PRIO_FLAGS);
  assign wr_psw  = wr_acc & (paddr == OFF_PSW);
  assign wr_clr  = wr_acc & (paddr == OFF_EVT_CLEAR);
  assign wr_en   = wr_acc & (paddr == OFF_EVT_ENABLE);

  always_comb begin
    psw_now              = PSW_RESET;
    psw_now[PSW_IE_BIT]  = ie_r;
    psw_now[PSW_ISP_BIT] = isp_r;
  end

  // ==========================================================================
  // Request edges
  logic [SRC_N-1:0] src_rise;

  req_edge_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .src_req  (src_req),
    .src_rise (src_rise)
  );

  // ==========================================================================
  // Eligibility and arbitration
  logic [SRC_N-1:0] pending;
  logic [SRC_N-1:0] level_ok;
  logic [SRC_N-1:0] eligible;
  logic             found;
  logic [SRC_W-1:0] winner;
  logic             defer_now;
  logic             boundary_ok;
  logic             take_maskable;
  logic             take_soft;

  assign pending = request_flags_r & ~mask_flags_r;
  // In high-level service only high-level sources qualify
  assign level_ok = isp_r ? {SRC_N{1'b1}} : ~source_priority_flag_r;  // [R06] [R07] [R03]
  assign eligible = (ie_r ? pending : '0) & level_ok;                   // [R04]

  prio_select u_sel (
    .cand   (eligible),
    .prio   (source_priority_flag_r),
    .found  (found),
    .winner (winner)
  );                                                                    // [R15]

  // Deferring class: status word access, returns, enable/disable
  assign defer_now = instr_defers | enable_interrupts_instr | disable_interrupts_instr
                   | return_from_vectored_instr | return_from_software_instr
                   | psw_load_instr;                                    // [R10]

  // Software interrupt is outside the deferring class
  assign take_soft = instr_done & software_interrupt_instr;             // [R08] [R12]

  // A return defers, so a held request waits one main instruction
  assign boundary_ok   = instr_done & ~defer_now & ~hold_r;             // [R09] [R05] [R17]
  assign take_maskable = boundary_ok & ~software_interrupt_instr & found; // [R12]

  // ==========================================================================
  // Hold flag for flag-register writes
  // A write lands inside an instruction; its own boundary and the next
  // one must pass before acceptance, so the flag spans two boundaries.
  logic       hold_one_r;
  logic       flag_wr;

  assign flag_wr = wr_req | wr_mask | wr_prio | wr_psw;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r     <= 1'b0;
      hold_one_r <= 1'b0;
    end else if (flag_wr) begin
      hold_r     <= 1'b1;                                               // [R11]
      hold_one_r <= 1'b1;
    end else if (instr_done && hold_one_r) begin
      hold_one_r <= 1'b0;
    end else if (instr_done) begin
      hold_r     <= 1'b0;
    end
  end

  // ==========================================================================
  // Request flags: set from edges, cleared by accept or software
  logic [SRC_N-1:0] accept_clr;

  assign accept_clr = take_maskable ? (SRC_N'(1) << winner) : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_flags_r <= REQ_RESET;
    end else begin
      // Set wins over any clear; priority plays no part here
      request_flags_r <= ((wr_req ? pwdata[SRC_N-1:0] : request_flags_r) & ~accept_clr)
                       | src_rise;                                      // [R13] [R04]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_flags_r <= MASK_RESET;
    end else if (wr_mask) begin
      mask_flags_r <= pwdata[SRC_N-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_priority_flag_r <= PRIO_RESET;
    end else if (wr_prio) begin
      source_priority_flag_r <= pwdata[SRC_N-1:0];
    end
  end

  // ==========================================================================
  // Status word flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_r  <= PSW_RESET[PSW_IE_BIT];
      isp_r <= PSW_RESET[PSW_ISP_BIT];
    end else if (take_soft) begin
      // Software service lets both levels nest once re-enabled
      ie_r  <= 1'b0;                                                    // [R01] [R12]
      isp_r <= 1'b1;                                                    // [R07]
    end else if (take_maskable) begin
      ie_r  <= 1'b0;                                                    // [R01]
      isp_r <= source_priority_flag_r[winner];                          // [R14]
    end else if (instr_done && (return_from_vectored_instr || return_from_software_instr
                                || psw_load_instr)) begin
      ie_r  <= psw_load_value[PSW_IE_BIT];                              // [R16]
      isp_r <= psw_load_value[PSW_ISP_BIT];
    end else if (instr_done && enable_interrupts_instr) begin
      ie_r  <= 1'b1;                                                    // [R02]
    end else if (instr_done && disable_interrupts_instr) begin
      ie_r  <= 1'b0;
    end else if (wr_psw) begin
      ie_r  <= pwdata[PSW_IE_BIT];
      isp_r <= pwdata[PSW_ISP_BIT];
    end
  end

  // ==========================================================================
  // Acceptance outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accept_pulse_r    <= 1'b0;
      accept_maskable_r <= 1'b0;
      accept_source_r   <= '0;
      stacked_psw_r     <= PSW_RESET;
    end else begin
      accept_pulse_r    <= take_soft | take_maskable;
      accept_maskable_r <= take_maskable;
      if (take_soft || take_maskable) begin
        // Word the core pushes ahead of the program counter
        stacked_psw_r   <= psw_now;                                     // [R14]
        accept_source_r <= take_maskable ? winner : '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      service_src_r <= '0;
    end else if (take_maskable) begin
      service_src_r <= winner;
    end
  end

  // ==========================================================================
  // Event status, enable and interrupt line
  logic [EVT_N-1:0] evt_set;
  logic             held_evt;

  // A boundary where something waits but no maskable request is taken
  assign held_evt = instr_done & (|pending) & ~take_maskable;          // [R04]

  always_comb begin
    evt_set             = '0;
    evt_set[EVT_ACCEPT] = take_maskable;
    evt_set[EVT_HELD]   = held_evt;
    evt_set[EVT_SWINT]  = take_soft;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status_r <= EVT_RESET;
    end else begin
      // Set wins over a clear in the same cycle
      evt_status_r <= (evt_status_r & ~(wr_clr ? pwdata[EVT_N-1:0] : '0)) | evt_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_enable_r <= EVT_RESET;
    end else if (wr_en) begin
      evt_enable_r <= pwdata[EVT_N-1:0];
    end
  end

  // ==========================================================================
  // Read data, captured in the setup phase
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (paddr)
      OFF_REQ_FLAGS:  rd_word[SRC_N-1:0] = request_flags_r;
      OFF_MASK_FLAGS: rd_word[SRC_N-1:0] = mask_flags_r;
      OFF_PRIO_FLAGS: rd_word[SRC_N-1:0] = source_priority_flag_r;
      OFF_PSW:        rd_word[7:0]       = psw_now;
      OFF_EVT_STATUS: rd_word[EVT_N-1:0] = evt_status_r;
      OFF_EVT_ENABLE: rd_word[EVT_N-1:0] = evt_enable_r;
      OFF_SERVICE:    rd_word[SRC_W-1:0] = service_src_r;
      default:        rd_word            = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r  <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr_r <= ~addr_ok;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata                = prdata_r;
  assign pslverr               = pslverr_r & psel & penable;
  assign accept_pulse          = accept_pulse_r;
  assign accept_maskable       = accept_maskable_r;
  assign accept_source         = accept_source_r;
  assign stacked_psw           = stacked_psw_r;
  assign accept_enable_flag    = ie_r;
  assign in_service_level_flag = isp_r;
  assign irq                   = |(evt_status_r & evt_enable_r);

endmodule // nest_accept

// File: hw/nest_accept_pkg.sv
package nest_accept_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned SRC_N  = 16;
  localparam int unsigned SRC_W  = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned EVT_N  = 3;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_REQ_FLAGS  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MASK_FLAGS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PRIO_FLAGS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PSW        = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_EVT_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_EVT_CLEAR  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_EVT_ENABLE = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_SERVICE    = 8'h1c;

  // ==========================================================================
  // Program status word layout and reset values
  localparam int unsigned PSW_IE_BIT  = 7;
  localparam int unsigned PSW_ISP_BIT = 1;
  localparam logic [7:0]  PSW_RESET   = 8'h02;
  localparam logic [SRC_N-1:0] REQ_RESET  = 16'h0000;
  localparam logic [SRC_N-1:0] MASK_RESET = 16'hffff;
  localparam logic [SRC_N-1:0] PRIO_RESET = 16'hffff;
  localparam logic [EVT_N-1:0] EVT_RESET  = 3'h0;

  // ==========================================================================
  // Event bits
  localparam int unsigned EVT_ACCEPT = 0;
  localparam int unsigned EVT_HELD   = 1;
  localparam int unsigned EVT_SWINT  = 2;

  // Priority flag values
  localparam logic PRIO_HIGH = 1'b0;

endpackage

// File: hw/req_edge_sync.sv
`timescale 1ns/1ps
module req_edge_sync
  import nest_accept_pkg::*;
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Raw request lines
  input  wire logic [SRC_N-1:0] src_req,
  // One-cycle rising-edge pulses
  output logic      [SRC_N-1:0] src_rise
);

  logic [SRC_N-1:0] meta_r;
  logic [SRC_N-1:0] sync_r;
  logic [SRC_N-1:0] last_r;

  // ==========================================================================
  // Per-source synchroniser and edge detector
  genvar g;
  generate
    for (g = 0; g < SRC_N; g++) begin : g_src
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
          last_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= src_req[g];
          sync_r[g] <= meta_r[g];
          last_r[g] <= sync_r[g];
        end
      end
      assign src_rise[g] = sync_r[g] & ~last_r[g];
    end
  endgenerate

endmodule // req_edge_sync

// File: hw/prio_select.sv
`timescale 1ns/1ps
module prio_select
  import nest_accept_pkg::*;
(
  // Candidate requests and their priority flags
  input  wire logic [SRC_N-1:0] cand,
  input  wire logic [SRC_N-1:0] prio,
  // Winner
  output logic                  found,
  output logic      [SRC_W-1:0] winner
);

  logic [SRC_N-1:0] hi_cand;
  logic [SRC_N-1:0] pick_set;

  // High level first; lower index wins ties (fixed default order)
  assign hi_cand  = cand & ~prio;
  assign pick_set = (|hi_cand) ? hi_cand : cand;
  assign found    = |cand;

  always_comb begin
    winner = '0;
    for (int i = SRC_N - 1; i >= 0; i--) begin
      if (pick_set[i]) begin
        winner = SRC_W'(i);
      end
    end
  end

endmodule // prio_select

// File: verif/nest_accept_chk.sv
`timescale 1ns/1ps
module nest_accept_chk (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Core side
  input  wire logic       instr_done,
  input  wire logic       instr_defers,
  input  wire logic       enable_interrupts_instr,
  input  wire logic       disable_interrupts_instr,
  input  wire logic       software_interrupt_instr,
  input  wire logic       return_from_vectored_instr,
  input  wire logic       return_from_software_instr,
  input  wire logic       psw_load_instr,
  input  wire logic [7:0] psw_load_value,
  // Acceptance and flags
  input  wire logic       accept_pulse,
  input  wire logic       accept_maskable,
  input  wire logic [7:0] stacked_psw,
  input  wire logic       accept_enable_flag,
  input  wire logic       in_service_level_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic       restore_i;
  logic       defer_i;
  logic       mask_acc;
  logic [1:0] ld_flags;
  assign restore_i = return_from_vectored_instr || return_from_software_instr || psw_load_instr;
  assign defer_i   = instr_defers || enable_interrupts_instr || disable_interrupts_instr || restore_i;
  assign mask_acc  = accept_pulse && accept_maskable;
  assign ld_flags  = {psw_load_value[7], psw_load_value[1]};

  // ======
  // Assertions
  a_accept_clears_ie: assert property (accept_pulse |-> !accept_enable_flag)
    else $error("accept left enable set");
  a_ei_sets_ie: assert property (instr_done && enable_interrupts_instr && !software_interrupt_instr
    && !restore_i |=> accept_enable_flag) else $error("enable instr did not set flag");
  a_di_clears_ie: assert property (instr_done && disable_interrupts_instr && !enable_interrupts_instr
    && !restore_i |=> !accept_enable_flag) else $error("disable instr did not clear flag");
  a_defer_holds: assert property (instr_done && defer_i |=> !mask_acc)
    else $error("accept at deferring boundary");
  a_disabled_holds: assert property (instr_done && !accept_enable_flag |=> !mask_acc)
    else $error("accept while disabled");
  a_high_nest_only: assert property (mask_acc && !$past(in_service_level_flag) |-> !in_service_level_flag)
    else $error("low level nested in high service");
  a_swi_taken: assert property (instr_done && software_interrupt_instr |=> accept_pulse && !accept_maskable)
    else $error("software interrupt not taken");
  a_swi_blocks_ie: assert property (instr_done && software_interrupt_instr |=> !accept_enable_flag)
    else $error("software interrupt kept enable");
  a_restore_word: assert property (instr_done && restore_i && !software_interrupt_instr
    |=> {accept_enable_flag, in_service_level_flag} == $past(ld_flags)) else $error("flags not restored");
  a_accept_on_boundary: assert property (accept_pulse |-> $past(instr_done))
    else $error("accept without boundary");
  a_stack_saved: assert property (accept_pulse |-> stacked_psw[7] == $past(accept_enable_flag)
    && stacked_psw[1] == $past(in_service_level_flag)) else $error("stacked word wrong");

  c_maskable: cover property (mask_acc);
  c_software: cover property (accept_pulse && !accept_maskable);
  c_restore: cover property (instr_done && restore_i);
  c_high_nest: cover property (mask_acc && !$past(in_service_level_flag));
endmodule // nest_accept_chk

// File: verif/core_seq_model.sv
`timescale 1ns/1ps
module core_seq_model (
  // Clock
  input  wire logic                          pclk,
  // Peripheral request lines
  output logic [nest_accept_pkg::SRC_N-1:0]  src_req,
  // Instruction boundary and class
  output logic                               instr_done,
  output logic                               instr_defers,
  output logic                               enable_interrupts_instr,
  output logic                               disable_interrupts_instr,
  output logic                               software_interrupt_instr,
  output logic                               return_from_vectored_instr,
  output logic                               return_from_software_instr,
  output logic                               psw_load_instr,
  output logic [7:0]                         psw_load_value
);
  import nest_accept_pkg::*;
  logic       act;
  logic [2:0] knd;
  initial begin
    act = 1'b0;
    knd = 3'h0;
    src_req = '0;
    psw_load_value = 8'h00;
  end
  assign instr_done                 = act;
  assign enable_interrupts_instr    = act && (knd == 3'h1);
  assign disable_interrupts_instr   = act && (knd == 3'h2);
  assign software_interrupt_instr   = act && (knd == 3'h3);
  assign return_from_vectored_instr = act && (knd == 3'h4);
  assign return_from_software_instr = act && (knd == 3'h5);
  assign instr_defers               = act && (knd == 3'h6);
  assign psw_load_instr             = act && (knd == 3'h7);

  // One boundary; operand word inverted afterwards so stale data never passes
  task automatic step(input logic [2:0] k, input logic [7:0] v);
    @(posedge pclk);
    act <= 1'b1;
    knd <= k;
    psw_load_value <= v;
    @(posedge pclk);
    act <= 1'b0;
    psw_load_value <= ~v;
  endtask

  task automatic raise(input logic [SRC_N-1:0] m);
    @(posedge pclk);
    src_req <= m;
  endtask
endmodule // core_seq_model

// File: verif/nest_accept_tb.sv
`timescale 1ns/1ps
module nest_accept_tb;
  import nest_accept_pkg::*;
  // ======
  // Signals
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [SRC_N-1:0]  src_req;
  logic              instr_done, instr_defers, enable_interrupts_instr, disable_interrupts_instr;
  logic              software_interrupt_instr, return_from_vectored_instr, return_from_software_instr;
  logic              psw_load_instr, accept_pulse, accept_maskable, accept_enable_flag;
  logic              in_service_level_flag, irq;
  logic [7:0]        psw_load_value, stacked_psw;
  logic [SRC_W-1:0]  accept_source;
  int                failures, cmp_count, cyc;

  nest_accept DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .src_req, .instr_done, .instr_defers, .enable_interrupts_instr, .disable_interrupts_instr,
    .software_interrupt_instr, .return_from_vectored_instr, .return_from_software_instr, .psw_load_instr,
    .psw_load_value, .accept_pulse, .accept_maskable, .accept_source, .stacked_psw, .accept_enable_flag,
    .in_service_level_flag, .irq);
  core_seq_model core (.pclk, .src_req, .instr_done, .instr_defers, .enable_interrupts_instr,
    .disable_interrupts_instr, .software_interrupt_instr, .return_from_vectored_instr,
    .return_from_software_instr, .psw_load_instr, .psw_load_value);

  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  // ======
  // Tasks
  task automatic test_done;
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  // Waits for pready with no fixed latency; the cycle counter cuts a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic bnd(input logic [2:0] k, input logic [7:0] v, input logic [1:0] ea, input logic [3:0] es,
                     input logic [1:0] ef);
    core.step(k, v);
    @(negedge pclk);
    chk(32'({accept_pulse, accept_maskable}), 32'(ea), "accept");
    if (ea[1]) chk(32'(accept_source), 32'(es), "source");
    chk(32'({accept_enable_flag, in_service_level_flag}), 32'(ef), "flags");
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      test_done;
    end
  end

  // ======
  // Sequence
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = '0;
    pwdata = '0;
    failures = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_PSW, 32'h0);
    chk(rd, 32'(PSW_RESET), "status word reset");
    apb(1'b0, OFF_MASK_FLAGS, 32'h0);
    chk(rd, 32'(MASK_RESET), "mask reset");
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped");
    apb(1'b1, OFF_MASK_FLAGS, 32'h0);
    apb(1'b1, OFF_PRIO_FLAGS, 32'h0000_ffdf);
    apb(1'b1, OFF_EVT_ENABLE, 32'h1);
    bnd(3'h0, 8'h00, 2'b00, 4'h0, 2'b01);
    bnd(3'h1, 8'h00, 2'b00, 4'h0, 2'b11);
    core.raise(16'h0024);
    repeat (4) @(posedge pclk);
    apb(1'b0, OFF_REQ_FLAGS, 32'h0);
    chk(rd, 32'h0024, "both flags set");
    bnd(3'h0, 8'h00, 2'b11, 4'h5, 2'b00);
    chk(32'(irq), 32'h1, "irq on accept");
    apb(1'b0, OFF_REQ_FLAGS, 32'h0);
    chk(rd, 32'h0004, "low source held");
    bnd(3'h0, 8'h00, 2'b00, 4'h0, 2'b00);
    bnd(3'h1, 8'h00, 2'b00, 4'h0, 2'b10);
    bnd(3'h0, 8'h00, 2'b00, 4'h0, 2'b10);
    bnd(3'h3, 8'h00, 2'b10, 4'h0, 2'b01);
    bnd(3'h5, 8'h80, 2'b00, 4'h0, 2'b10);
    bnd(3'h0, 8'h00, 2'b00, 4'h0, 2'b10);
    bnd(3'h4, 8'h82, 2'b00, 4'h0, 2'b11);
    apb(1'b1, OFF_PRIO_FLAGS, 32'h0000_ffdf);
    bnd(3'h0, 8'h00, 2'b00, 4'h0, 2'b11);
    bnd(3'h0, 8'h00, 2'b00, 4'h0, 2'b11);
    bnd(3'h0, 8'h00, 2'b11, 4'h2, 2'b01);
    core.raise(16'h0000);
    repeat (4) @(posedge pclk);
    core.raise(16'h0004);
    repeat (4) @(posedge pclk);
    bnd(3'h1, 8'h00, 2'b00, 4'h0, 2'b11);
    bnd(3'h6, 8'h00, 2'b00, 4'h0, 2'b11);
    bnd(3'h2, 8'h00, 2'b00, 4'h0, 2'b01);
    bnd(3'h7, 8'h82, 2'b00, 4'h0, 2'b11);
    bnd(3'h0, 8'h00, 2'b11, 4'h2, 2'b01);
    apb(1'b1, OFF_PSW, 32'h0000_0080);
    core.raise(16'h0024);
    repeat (4) @(posedge pclk);
    bnd(3'h0, 8'h00, 2'b00, 4'h0, 2'b10);
    bnd(3'h0, 8'h00, 2'b00, 4'h0, 2'b10);
    bnd(3'h0, 8'h00, 2'b11, 4'h5, 2'b00);
    apb(1'b0, OFF_SERVICE, 32'h0);
    chk(rd, 32'h0000_0005, "service source");
    apb(1'b1, OFF_EVT_ENABLE, 32'h0);
    @(negedge pclk);
    chk(32'(irq), 32'h0, "irq masked");
    apb(1'b0, OFF_EVT_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1, "accept event sticky");
    apb(1'b1, OFF_EVT_CLEAR, 32'h7);
    apb(1'b1, OFF_EVT_ENABLE, 32'h1);
    apb(1'b0, OFF_EVT_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h0, "event cleared");
    chk(32'(irq), 32'h0, "irq after clear");
    apb(1'b1, OFF_REQ_FLAGS, 32'h0000_0001);
    apb(1'b0, OFF_REQ_FLAGS, 32'h0);
    chk(rd, 32'h0000_0001, "request flag write");
    test_done;
  end
endmodule // nest_accept_tb

bind nest_accept nest_accept_chk u_chk (.pclk, .presetn, .instr_done, .instr_defers, .enable_interrupts_instr,
  .disable_interrupts_instr, .software_interrupt_instr, .return_from_vectored_instr,
  .return_from_software_instr, .psw_load_instr, .psw_load_value, .accept_pulse, .accept_maskable,
  .stacked_psw, .accept_enable_flag, .in_service_level_flag);
